// *** tb/rx_limit_checker.sv ***
// Purpose: Port checks for the receive-control and count-limit block.
// Assumes: One clock; limit and mask shadows follow APB writes.
// Notes:   Bound to every instance of the block.
module rx_limit_checker (
  // Clock and reset.
  input wire logic                            pclk,
  input wire logic                            presetn,
  // APB.
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [rx_limit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                     pwdata,
  // Datapath.
  input wire rx_limit_pkg::tai_in_s           tai_in,
  input wire rx_limit_pkg::tai_out_s          tai_out
);
  import rx_limit_pkg::*;
  tai_in_s     i;
  tai_out_s    o;
  logic [11:0] lim_q;
  logic [1:0]  en_q;
  logic        wr;
  assign i = tai_in;
  assign o = tai_out;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_q <= 12'h000;
      en_q  <= 2'h0;
    end else if (wr) begin
      if (paddr == OFF_COUNT_LIMIT_HIGH) lim_q[11:8] <= pwdata[3:0];
      if (paddr == OFF_COUNT_LIMIT_LOW) lim_q[7:0] <= pwdata[7:0];
      if (paddr == OFF_COUNT_IRQ_ENABLE) en_q <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tx_count_step: assert property (i.tx_active && i.tx_byte && !i.tx_crc_phase && !i.tx_frame_start
    |=> o.byte_count == $past(o.byte_count) + 12'h001) else $error("tx byte not counted");
  a_tx_check_skip: assert property (i.tx_active && i.tx_crc_phase && !i.tx_frame_start
    |=> o.byte_count == $past(o.byte_count)) else $error("tx check byte counted");
  a_tx_limit_hit: assert property (i.tx_active && i.tx_byte && !i.tx_crc_phase && !i.tx_frame_start
    && en_q[0] && o.byte_count + 12'h001 == lim_q |=> o.transmit_count_interrupt) else $error("tx limit missed");
  a_rx_irq_cause: assert property (o.receive_count_interrupt |-> en_q[1] && o.byte_count == lim_q)
    else $error("rx interrupt without cause");
  a_irq_one_pulse: assert property (o.receive_count_interrupt |=> !o.receive_count_interrupt)
    else $error("rx interrupt longer than one cycle");
  a_ctrl_out_bits: assert property (wr && paddr == OFF_RECEIVE_CONTROL |=> o.receive_reset_control ==
    $past(pwdata[7]) && o.receive_fifo_reset_control == $past(pwdata[6])) else $error("control outputs wrong");
  a_dma_follows: assert property (o.dma_request_indication == ($past(i.rx_fifo_level) != 4'h0))
    else $error("dma request wrong");
  a_reset_stops: assert property (o.receive_reset_control [*2] |-> !o.rx_machine_run)
    else $error("receive reset did not stop");
  c_rx_irq: cover property (o.receive_count_interrupt);
  c_tx_irq: cover property (o.transmit_count_interrupt);
  c_run: cover property ($rose(o.rx_machine_run));
endmodule
bind rx_control_and_count_limit rx_limit_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tai_in(tai_in), .tai_out(tai_out));

// *** tb/tai_model.sv ***
// Purpose: Transceiver datapath model driving byte and check strobes.
// Assumes: Strobes change by non-blocking assignment after a rising edge.
// Notes:   All strobes are low between frames.
module tai_model (
  // Clock.
  input wire logic              pclk,
  // Datapath strobes.
  output rx_limit_pkg::tai_in_s tai_in
);
  import rx_limit_pkg::*;
  initial tai_in = '0;
  // Sends n counted bytes, then c check bytes, g cycles after each byte; receive strobes drop in them, transmit strobes hold.
  task automatic frame(input logic tx, input int n, input int c, input int g);
    @(posedge pclk);
    tai_in.tx_active <= tx;
    tai_in.tx_frame_start <= tx;
    tai_in.rx_sfd <= !tx;
    for (int k = 0; k < n + c; k++) begin
      @(posedge pclk);
      tai_in.tx_frame_start <= 1'b0;
      tai_in.rx_sfd <= 1'b0;
      tai_in.tx_byte <= tx;
      tai_in.tx_crc_phase <= tx && k >= n;
      tai_in.rx_fifo_write <= !tx;
      tai_in.short_check_good <= !tx && k == 2;
      tai_in.rx_fifo_level <= tx ? 4'h0 : 4'(k + 1);
      repeat (g) begin
        @(posedge pclk);
        tai_in.rx_fifo_write <= 1'b0;
        tai_in.short_check_good <= 1'b0;
      end
    end
    @(posedge pclk);
    tai_in <= {6'h00, !tx, !tx, 6'h00};
    @(posedge pclk);
    tai_in <= '0;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the receive-control and count-limit block.
// Assumes: APB master waits for pready; datapath from the model.
// Notes:   Register rows first, then reset and receive and transmit cases.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rx_limit_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, perr;
  tai_in_s     tai_in;
  tai_out_s    tai_out;
  int          err_total = 0, n_tests = 0, rx_irqs = 0, tx_irqs = 0;
  row_s rows[5] = '{'{OFF_COUNT_LIMIT_HIGH, 32'hff, 32'h0f}, '{OFF_RECEIVE_CONTROL, 32'hfe, 32'hc0},
    '{OFF_RECEIVE_CONTROL, 32'h00, 32'h00}, '{OFF_RECEIVE_STATUS, 32'hff, 32'h00},
    '{OFF_COUNT_IRQ_ENABLE, 32'h03, 32'h03}};
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    rx_irqs += int'(tai_out.receive_count_interrupt === 1'b1);
    tx_irqs += int'(tai_out.transmit_count_interrupt === 1'b1);
  end
  rx_control_and_count_limit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tai_in(tai_in), .tai_out(tai_out));
  tai_model i_tai (.pclk(pclk), .tai_in(tai_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog far above the roughly 150 cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].e);
    end
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_COUNT_LIMIT_HIGH, 32'h0);
    rd(OFF_RECEIVE_CONTROL, 32'h0);
    apb(1'b1, OFF_COUNT_LIMIT_LOW, 32'h3);
    apb(1'b1, OFF_COUNT_IRQ_ENABLE, 32'h3);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h1);
    settle(2);
    chk(tai_out.rx_machine_run, 32'h1);
    rd(OFF_RECEIVE_STATUS, 32'h1);
    i_tai.frame(1'b0, 5, 0, 1);
    chk(rx_irqs, 32'h1);
    rd(OFF_BYTE_COUNT, 32'h5);
    rd(OFF_RECEIVE_STATUS, 32'hc1);
    rd(OFF_LONG_CHECK_COUNT, 32'h5);
    rd(OFF_SHORT_CHECK_COUNT, 32'h2);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h1);
    settle(3);
    chk(tai_out.rx_machine_run, 32'h0);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h0);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h1);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h0);
    settle(1);
    chk(tai_out.rx_machine_run, 32'h1);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h80);
    settle(2);
    chk(tai_out.rx_machine_run, 32'h0);
    rd(OFF_RECEIVE_STATUS, 32'h0);
    apb(1'b1, OFF_RECEIVE_CONTROL, 32'h0);
    apb(1'b1, OFF_COUNT_IRQ_ENABLE, 32'h1);
    i_tai.frame(1'b1, 4, 2, 0);
    rd(OFF_BYTE_COUNT, 32'h4);
    apb(1'b1, OFF_COUNT_IRQ_ENABLE, 32'h0);
    i_tai.frame(1'b1, 4, 2, 0);
    chk(tx_irqs, 32'h1);
    rd(8'h40, 32'h0);
    chk(perr, 32'h1);
    print_verdict();
  end
endmodule

// *** verilog/rx_control_and_count_limit.sv ***
// Purpose: Receive control, receive status and byte count limit logic with an APB register port.
// Assumes: All datapath strobes are on pclk; APB master holds requests until pready.
// Notes:   pready is always high, so every access completes in its first access cycle.
//
// Functional notes
// - Limit-high register low nibble holds limit bits 11:8, reset zero.
// - Transmit count interrupt fires at limit during transmit when unmasked.
// - Transmit counting starts after delimiter and skips appended check bytes.
// - Receive count interrupt fires at limit during reception when unmasked.
// - Receive counting covers every byte after the start-of-frame delimiter.
// - Reaching the limit only signals; no state or FIFO effect.
// - Reserved bits written as zero by software; reads return zero here.
// - Control bit 7 drives the receive reset while set.
// - Receive reset leaves the receive FIFO alone; only FIFO reset clears it.
// - Control bit 6 drives the receive FIFO reset while set.
// - Setting control bit 0 starts the receive state machine.
// - Start acts on a rising edge; clear and set again to restart.
// - DMA request follows FIFO status regardless of the start bit.
// - Clearing start does not abort; only receive reset or the core reset bit aborts.
// - Starting reception sets the receive busy flag.
// - Long check good sets status bit 7 and latches the byte count.
// - Short check good sets status bit 6 and latches the byte count.
// - Busy stays set until receive reset, core reset bit or global reset.
// - Receive counter counts FIFO writes, including header and check bytes.
//
// Register access over APB and the placing of the registers were decided locally.
module rx_control_and_count_limit
  import rx_limit_pkg::*;
(
  // Clock and reset.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rx_limit_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Transceiver datapath.
  input  wire rx_limit_pkg::tai_in_s      tai_in,
  output rx_limit_pkg::tai_out_s          tai_out
);
  import rx_limit_pkg::*;

  typedef struct packed {
    logic [7:0]              limit_low;
    logic [LIMIT_HIGH_W-1:0] limit_high;
    logic                    rx_reset;
    logic                    fifo_reset;
    logic                    start;
    logic                    start_prev;
    logic [1:0]              irq_en;
    rx_state_e               rx_state;
    logic                    busy;
    logic                    long_good;
    logic                    short_good;
    logic [COUNT_W-1:0]      count;
    logic [COUNT_W-1:0]      long_count;
    logic [COUNT_W-1:0]      short_count;
    logic                    tx_irq;
    logic                    rx_irq;
    logic                    dma_req;
    logic [31:0]             rdata;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic               wr_en;
  logic               setup;
  logic               mapped;
  logic [31:0]        rd_mux;
  logic [COUNT_W-1:0] limit;
  logic [COUNT_W-1:0] count_inc;
  logic               start_rise;
  logic               tx_count_en;
  logic               rx_count_en;
  logic               clear_count;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = state_q.rdata;

  assign limit     = {state_q.limit_high, state_q.limit_low};
  assign count_inc = state_q.count + 12'h001;

  // Address decode and read data.
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_COUNT_LIMIT_HIGH: rd_mux[LIMIT_HIGH_W-1:0] = state_q.limit_high;
      OFF_RECEIVE_CONTROL: begin
        rd_mux[POS_RX_RESET]   = state_q.rx_reset;
        rd_mux[POS_FIFO_RESET] = state_q.fifo_reset;
        rd_mux[POS_RX_START]   = state_q.start;
      end
      OFF_RECEIVE_STATUS: begin
        rd_mux[POS_LONG_GOOD]  = state_q.long_good;
        rd_mux[POS_SHORT_GOOD] = state_q.short_good;
        rd_mux[POS_RX_BUSY]    = state_q.busy;
      end
      OFF_COUNT_LIMIT_LOW:   rd_mux[7:0] = state_q.limit_low;
      OFF_COUNT_IRQ_ENABLE:  rd_mux[1:0] = state_q.irq_en;
      OFF_BYTE_COUNT:        rd_mux[COUNT_W-1:0] = state_q.count;
      OFF_LONG_CHECK_COUNT:  rd_mux[COUNT_W-1:0] = state_q.long_count;
      OFF_SHORT_CHECK_COUNT: rd_mux[COUNT_W-1:0] = state_q.short_count;
      default:               mapped = 1'b0;
    endcase
  end

  // Counting qualifiers.
  assign start_rise  = state_q.start && !state_q.start_prev && !state_q.rx_reset;
  assign tx_count_en = tai_in.tx_active && tai_in.tx_byte && !tai_in.tx_crc_phase;
  assign rx_count_en = !tai_in.tx_active && (state_q.rx_state == RX_FRAME) && tai_in.rx_fifo_write;
  assign clear_count = (tai_in.tx_active && tai_in.tx_frame_start) ||
                       (!tai_in.tx_active && (state_q.rx_state == RX_ARMED) && tai_in.rx_sfd);

  always_comb begin
    state_d = state_q;
    state_d.rdata      = setup ? rd_mux : state_q.rdata;
    state_d.start_prev = state_q.start;
    state_d.tx_irq     = 1'b0;
    state_d.rx_irq     = 1'b0;
    state_d.dma_req    = tai_in.rx_fifo_level != 4'h0;

    // Register writes; reserved bits are dropped.
    if (wr_en) begin
      case (paddr)
        OFF_COUNT_LIMIT_HIGH: state_d.limit_high = pwdata[LIMIT_HIGH_W-1:0];
        OFF_RECEIVE_CONTROL: begin
          state_d.rx_reset   = pwdata[POS_RX_RESET];
          state_d.fifo_reset = pwdata[POS_FIFO_RESET];
          state_d.start      = pwdata[POS_RX_START];
        end
        OFF_COUNT_LIMIT_LOW:  state_d.limit_low = pwdata[7:0];
        OFF_COUNT_IRQ_ENABLE: state_d.irq_en = pwdata[1:0];
        default: ;
      endcase
    end

    // Receive state machine; dropping start never aborts.
    case (state_q.rx_state)
      RX_IDLE: begin
        if (start_rise) begin
          state_d.rx_state = RX_ARMED;
        end
      end
      RX_ARMED: begin
        if (!tai_in.tx_active && tai_in.rx_sfd) begin
          state_d.rx_state = RX_FRAME;
        end
      end
      RX_FRAME: begin
        if (tai_in.rx_frame_end) begin
          state_d.rx_state = RX_IDLE;
        end
      end
      default: state_d.rx_state = RX_IDLE;
    endcase

    // Byte counter and one-shot limit indications.
    if (clear_count) begin
      state_d.count = RST_COUNT;
    end else if (tx_count_en || rx_count_en) begin
      state_d.count = count_inc;
      if (count_inc == limit) begin
        state_d.tx_irq = tx_count_en && state_q.irq_en[POS_TX_IRQ_EN];
        state_d.rx_irq = rx_count_en && state_q.irq_en[POS_RX_IRQ_EN];
      end
    end

    // Check-good flags clear at a new receive frame, but a set in the same cycle wins.
    if (clear_count && !tai_in.tx_active) begin
      state_d.long_good  = 1'b0;
      state_d.short_good = 1'b0;
    end
    if (tai_in.long_check_good) begin
      state_d.long_good  = 1'b1;
      state_d.long_count = state_q.count;
    end
    if (tai_in.short_check_good) begin
      state_d.short_good  = 1'b1;
      state_d.short_count = state_q.count;
    end

    // Busy sets on start and holds until a receive or core reset.
    if (start_rise && state_q.rx_state == RX_IDLE) begin
      state_d.busy = 1'b1;
    end

    // Receive reset or core reset bit aborts reception and clears busy and check-good flags; the FIFO reset line is separate.
    if (state_q.rx_reset || tai_in.core_reset_bit) begin
      state_d.rx_state   = RX_IDLE;
      state_d.busy       = 1'b0;
      state_d.long_good  = 1'b0;
      state_d.short_good = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q             <= '0;
      state_q.limit_low   <= RST_LIMIT_LOW;
      state_q.limit_high  <= RST_LIMIT_HIGH;
      state_q.irq_en      <= RST_IRQ_EN;
      state_q.rx_state    <= RX_IDLE;
      state_q.count       <= RST_COUNT;
      state_q.long_count  <= RST_COUNT;
      state_q.short_count <= RST_COUNT;
      state_q.busy        <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tai_out.receive_reset_control      = state_q.rx_reset;
  assign tai_out.receive_fifo_reset_control = state_q.fifo_reset;
  assign tai_out.rx_machine_run             = state_q.rx_state != RX_IDLE;
  assign tai_out.transmit_count_interrupt   = state_q.tx_irq;
  assign tai_out.receive_count_interrupt    = state_q.rx_irq;
  assign tai_out.dma_request_indication     = state_q.dma_req;
  assign tai_out.byte_count                 = state_q.count;

endmodule

// *** verilog/rx_limit_pkg.sv ***
// Purpose: Shared constants and carriers for the receive-control and byte-count-limit block.
// Assumes: 32-bit APB, one aligned word per register, core clock pclk.
// Notes:   Unused register bits read as zero.
package rx_limit_pkg;

  localparam int unsigned COUNT_W = 12;
  localparam int unsigned ADDR_W  = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_COUNT_LIMIT_HIGH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RECEIVE_CONTROL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RECEIVE_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LIMIT_LOW  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_COUNT_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BYTE_COUNT       = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LONG_CHECK_COUNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SHORT_CHECK_COUNT = 8'h1c;

  // Field positions.
  localparam int unsigned POS_RX_RESET    = 7;
  localparam int unsigned POS_FIFO_RESET  = 6;
  localparam int unsigned POS_RX_START    = 0;
  localparam int unsigned POS_LONG_GOOD   = 7;
  localparam int unsigned POS_SHORT_GOOD  = 6;
  localparam int unsigned POS_RX_BUSY     = 0;
  localparam int unsigned POS_TX_IRQ_EN   = 0;
  localparam int unsigned POS_RX_IRQ_EN   = 1;
  localparam int unsigned LIMIT_HIGH_W    = 4;

  // Reset values.
  localparam logic [7:0]         RST_LIMIT_LOW  = 8'h00;
  localparam logic [3:0]         RST_LIMIT_HIGH = 4'h0;
  localparam logic [COUNT_W-1:0] RST_COUNT      = 12'h000;
  localparam logic [1:0]         RST_IRQ_EN     = 2'h0;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ARMED = 2'b01,
    RX_FRAME = 2'b10
  } rx_state_e;

  // Strobes from the transceiver datapath, all on pclk.
  typedef struct packed {
    logic       tx_active;
    logic       tx_frame_start;
    logic       tx_byte;
    logic       tx_crc_phase;
    logic       rx_sfd;
    logic       rx_fifo_write;
    logic       rx_frame_end;
    logic       long_check_good;
    logic       short_check_good;
    logic       core_reset_bit;
    logic [3:0] rx_fifo_level;
  } tai_in_s;

  typedef struct packed {
    logic               receive_reset_control;
    logic               receive_fifo_reset_control;
    logic               rx_machine_run;
    logic               transmit_count_interrupt;
    logic               receive_count_interrupt;
    logic               dma_request_indication;
    logic [COUNT_W-1:0] byte_count;
  } tai_out_s;

endpackage
